// ### core/dpm_pkg.sv
package dpm_pkg;

  // port geometry
  localparam int NPORTS = 2;
  localparam int PORT_LEFT = 0;
  localparam int PORT_RIGHT = 1;
  localparam int ADDR_W = 19;
  localparam int BE_W = 2;

  // layout of one port's pins inside the synchroniser vector
  localparam int PIN_CLK = 0;
  localparam int PIN_RW = 1;
  localparam int PIN_CE0_N = 2;
  localparam int PIN_CE1 = 3;
  localparam int PIN_CMS = 4;
  localparam int PIN_CLR_N = 5;
  localparam int PIN_ADS_N = 6;
  localparam int PIN_CEN_N = 7;
  localparam int PIN_WRAP = 8;
  localparam int PIN_BE_LO = 9;
  localparam int PIN_ADDR_LO = 11;
  localparam int PIN_W = 30;

  // mailbox locations: the two highest words of the array
  localparam logic [18:0] MBOX_ADDR_LEFT = 19'h7fffe;
  localparam logic [18:0] MBOX_ADDR_RIGHT = 19'h7ffff;

  // values after master reset, and the byte-enable pattern with no lane on
  localparam logic [18:0] COUNTER_RESET = 19'h00000;
  localparam logic [18:0] MASK_RESET = 19'h7ffff;
  localparam logic [1:0] BE_NONE_N = 2'h3;

  // apb register map (byte addresses)
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_PORT_ENABLE = 8'h0c;
  localparam logic [7:0] REG_COUNTER_LEFT = 8'h10;
  localparam logic [7:0] REG_COUNTER_RIGHT = 8'h14;
  localparam logic [7:0] REG_MASK_LEFT = 8'h18;
  localparam logic [7:0] REG_MASK_RIGHT = 8'h1c;
  localparam logic [7:0] REG_MIRROR_LEFT = 8'h20;
  localparam logic [7:0] REG_MIRROR_RIGHT = 8'h24;

  // interrupt status bits: mailbox set per port, counter wrap per port
  localparam int IRQ_W = 4;
  localparam int IRQ_MBOX_LO = 0;
  localparam int IRQ_WRAP_LO = 2;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [1:0] PORT_ENABLE_RESET = 2'h3;

endpackage

// ### core/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] settled_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit only moves once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          settled_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          settled_out[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule

// ### core/dpm_port_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - a write by the other port to a port's mailbox drives its interrupt low
// - the owner reading its own mailbox returns its interrupt high
// - the two highest addresses are mailboxes, one per port
// - counter wrap interrupt goes low when increment makes unmasked bits all ones
// - at maximum count with wrap select low, increment clears unmasked bits
// - at maximum count with wrap select high, increment reloads from mirror
// - master reset acts asynchronously and on both ports together
// - master reset zeroes counters, sets masks to ones, raises both ports' mailbox and wrap interrupts
// - counter select high: clear, load, readback, increment or hold by strobes
// - counter select low: mask reset, mask load or mask readback by strobes
// - right mailbox at 7ffff, left mailbox at 7fffe
module dpm_port_ctrl
  import dpm_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic MASTER_RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  input wire logic [1:0] PORT_CLK_IN,
  input wire logic [1:0][18:0] ADDR_IN,
  output logic [1:0][18:0] ADDR_OUT,
  output logic [1:0] ADDR_OE_OUT,
  input wire logic [1:0] READ_WRITE_IN,
  input wire logic [1:0][1:0] BYTE_ENABLE_N_IN,
  input wire logic [1:0] CHIP_ENABLE0_N_IN,
  input wire logic [1:0] CHIP_ENABLE1_IN,
  input wire logic [1:0] COUNTER_MASK_SELECT_IN,
  input wire logic [1:0] COUNTER_CLEAR_N_IN,
  input wire logic [1:0] ADDRESS_LOAD_STROBE_N_IN,
  input wire logic [1:0] COUNTER_ENABLE_N_IN,
  input wire logic [1:0] WRAP_MODE_SELECT_IN,
  output logic [1:0] MAILBOX_INT_N_OUT,
  output logic [1:0] COUNTER_WRAP_IRQ_N_OUT
);

  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] master_reset_n_sync;
  logic port_rst_n;
  logic [NPORTS*PIN_W-1:0] pins_raw;
  logic [NPORTS*PIN_W-1:0] pins;
  logic [NPORTS-1:0] clk_seen;
  logic [NPORTS-1:0] port_edge;
  logic [NPORTS-1:0] access_ok;
  logic [NPORTS-1:0] wr_other_mbox;
  logic [NPORTS-1:0] rd_own_mbox;
  logic [NPORTS-1:0] wrap_hit;
  logic [NPORTS-1:0] port_enable;
  logic [ADDR_W-1:0] counter [NPORTS];
  logic [ADDR_W-1:0] mask_reg [NPORTS];
  logic [ADDR_W-1:0] mirror [NPORTS];
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic apb_access;
  logic apb_write;
  logic [31:0] next_rdata;
  logic next_slverr;

  // apb state answers to system reset only, so it survives a master reset
  // system reset: asynchronous assert, released through two flops
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // master reset hits both ports at once without waiting for any clock;
  // its release is retimed so no port flop leaves reset on a ragged edge
  always_ff @(posedge REF_CLK_IN or negedge MASTER_RESET_N_IN) begin
    if (!MASTER_RESET_N_IN) begin
      master_reset_n_sync <= 2'h0;
    end else begin
      master_reset_n_sync <= {master_reset_n_sync[0], 1'b1};
    end
  end
  assign port_rst_n = rst_n & master_reset_n_sync[1];

  // gather each port's pins for the three-stage synchroniser
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_pack
      assign pins_raw[g*PIN_W+PIN_CLK] = PORT_CLK_IN[g];
      assign pins_raw[g*PIN_W+PIN_RW] = READ_WRITE_IN[g];
      assign pins_raw[g*PIN_W+PIN_CE0_N] = CHIP_ENABLE0_N_IN[g];
      assign pins_raw[g*PIN_W+PIN_CE1] = CHIP_ENABLE1_IN[g];
      assign pins_raw[g*PIN_W+PIN_CMS] = COUNTER_MASK_SELECT_IN[g];
      assign pins_raw[g*PIN_W+PIN_CLR_N] = COUNTER_CLEAR_N_IN[g];
      assign pins_raw[g*PIN_W+PIN_ADS_N] = ADDRESS_LOAD_STROBE_N_IN[g];
      assign pins_raw[g*PIN_W+PIN_CEN_N] = COUNTER_ENABLE_N_IN[g];
      assign pins_raw[g*PIN_W+PIN_WRAP] = WRAP_MODE_SELECT_IN[g];
      assign pins_raw[g*PIN_W+PIN_BE_LO +: BE_W] = BYTE_ENABLE_N_IN[g];
      assign pins_raw[g*PIN_W+PIN_ADDR_LO +: ADDR_W] = ADDR_IN[g];
    end
  endgenerate

  // limitation: each port clock phase must last four system cycles or more
  // port clock and its pins share one pipeline, so data stays aligned to its edge
  pin_sync3 #(
    .WIDTH(NPORTS*PIN_W)
  ) u_pin_sync (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .async_in(pins_raw),
    .settled_out(pins)
  );

  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      logic rw;
      logic ce;
      logic cms;
      logic clr_n;
      logic ads_n;
      logic cen_n;
      logic wrap_sel;
      logic [BE_W-1:0] be_n;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] access_addr;
      logic [ADDR_W-1:0] own_mbox;
      logic [ADDR_W-1:0] other_mbox;
      logic [ADDR_W-1:0] step;
      logic [ADDR_W-1:0] next_inc;
      logic [ADDR_W-1:0] counted;
      logic [ADDR_W-1:0] next_counter;
      logic at_max;
      logic do_inc;

      assign rw = pins[g*PIN_W+PIN_RW];
      assign ce = ~pins[g*PIN_W+PIN_CE0_N] & pins[g*PIN_W+PIN_CE1];
      assign cms = pins[g*PIN_W+PIN_CMS];
      assign clr_n = pins[g*PIN_W+PIN_CLR_N];
      assign ads_n = pins[g*PIN_W+PIN_ADS_N];
      assign cen_n = pins[g*PIN_W+PIN_CEN_N];
      assign wrap_sel = pins[g*PIN_W+PIN_WRAP];
      assign be_n = pins[g*PIN_W+PIN_BE_LO +: BE_W];
      assign addr = pins[g*PIN_W+PIN_ADDR_LO +: ADDR_W];

      // rising edge of this port's own clock; nothing else advances the port
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          clk_seen[g] <= 1'b0;
        end else begin
          clk_seen[g] <= pins[g*PIN_W+PIN_CLK];
        end
      end
      assign port_edge[g] = pins[g*PIN_W+PIN_CLK] & ~clk_seen[g];

      // the array is addressed by the pins while the load strobe is low, else by the counter
      assign access_addr = ads_n ? counter[g] : addr;
      assign own_mbox = (g == PORT_RIGHT) ? MBOX_ADDR_RIGHT : MBOX_ADDR_LEFT;
      assign other_mbox = (g == PORT_RIGHT) ? MBOX_ADDR_LEFT : MBOX_ADDR_RIGHT;
      // other-mailbox reads and own-mailbox writes touch neither flag
      // an access needs chip enable and at least one byte lane
      assign access_ok[g] = port_edge[g] & ce & (be_n != BE_NONE_N);
      assign wr_other_mbox[g] = access_ok[g] & ~rw & (access_addr == other_mbox);
      assign rd_own_mbox[g] = access_ok[g] & rw & (access_addr == own_mbox);

      // increment steps by the lowest unmasked bit, so masking bit 0 alone counts by two
      assign step = mask_reg[g] & (~mask_reg[g] + 19'h00001);
      // at_max looks at the count before this increment
      assign at_max = (counter[g] & mask_reg[g]) == mask_reg[g];
      // masked bits never move; the carry out of the top unmasked bit is dropped
      assign counted = ((counter[g] & mask_reg[g]) + step) & mask_reg[g];
      always_comb begin
        next_inc = (counter[g] & ~mask_reg[g]) | counted;
        if (at_max) begin
          if (wrap_sel) begin
            next_inc = mirror[g];
          end else begin
            next_inc = counter[g] & ~mask_reg[g];
          end
        end
      end
      assign do_inc = port_edge[g] & port_enable[g] & cms & clr_n & ads_n & ~cen_n;
      // a reload from the mirror may itself land on all ones and flag again
      assign wrap_hit[g] = do_inc & ((next_inc & mask_reg[g]) == mask_reg[g]);
      // counter clear keeps the masked bits
      assign next_counter = counter[g] & ~mask_reg[g];

      // counter and mirror: mirror follows every load and counter clear
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          counter[g] <= COUNTER_RESET;
          mirror[g] <= COUNTER_RESET;
        end else if (port_edge[g] && port_enable[g] && cms) begin
          if (!clr_n) begin
            counter[g] <= next_counter;
            mirror[g] <= next_counter;
          end else if (!ads_n && !cen_n) begin
            counter[g] <= addr;
            mirror[g] <= addr;
          end else if (ads_n && !cen_n) begin
            counter[g] <= next_inc;
          end
        end
      end

      // mask operations ignore chip enable, as counter operations do
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          mask_reg[g] <= MASK_RESET;
        end else if (port_edge[g] && port_enable[g] && !cms) begin
          if (!clr_n) begin
            mask_reg[g] <= MASK_RESET;
          end else if (!ads_n && !cen_n) begin
            mask_reg[g] <= addr;
          end
        end
      end

      // readback drives the address lines until this port's next clock edge
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          ADDR_OE_OUT[g] <= 1'b0;
          ADDR_OUT[g] <= COUNTER_RESET;
        end else if (port_edge[g]) begin
          ADDR_OE_OUT[g] <= port_enable[g] & clr_n & ~ads_n & cen_n;
          ADDR_OUT[g] <= cms ? counter[g] : mask_reg[g];
        end
      end

      // wrap flag falls when an increment lands on all ones, rises on the next counter change
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          COUNTER_WRAP_IRQ_N_OUT[g] <= 1'b1;
        end else if (wrap_hit[g]) begin
          COUNTER_WRAP_IRQ_N_OUT[g] <= 1'b0;
        end else if (port_edge[g] && port_enable[g] && cms && (!clr_n || !cen_n)) begin
          COUNTER_WRAP_IRQ_N_OUT[g] <= 1'b1;
        end
      end

      // a set from the other port in the same cycle as the owner's read wins
      always_ff @(posedge REF_CLK_IN or negedge port_rst_n) begin
        if (!port_rst_n) begin
          MAILBOX_INT_N_OUT[g] <= 1'b1;
        end else if (wr_other_mbox[NPORTS-1-g]) begin
          MAILBOX_INT_N_OUT[g] <= 1'b0;
        end else if (rd_own_mbox[g]) begin
          MAILBOX_INT_N_OUT[g] <= 1'b1;
        end
      end

      assign irq_event[IRQ_MBOX_LO+g] = wr_other_mbox[NPORTS-1-g];
      assign irq_event[IRQ_WRAP_LO+g] = wrap_hit[g];
    end
  endgenerate

  // apb: one wait state, answer registered; writes land on the completing edge
  assign apb_access = PSEL_IN & PENABLE_IN;
  // a write commits only on the edge that completes its transfer
  assign apb_write = apb_access & PREADY_OUT & PWRITE_IN;

  always_comb begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    case (PADDR_IN)
      REG_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      REG_FLAGS: next_rdata[3:0] = {COUNTER_WRAP_IRQ_N_OUT, MAILBOX_INT_N_OUT};
      REG_PORT_ENABLE: next_rdata[NPORTS-1:0] = port_enable;
      REG_COUNTER_LEFT: next_rdata[ADDR_W-1:0] = counter[PORT_LEFT];
      REG_COUNTER_RIGHT: next_rdata[ADDR_W-1:0] = counter[PORT_RIGHT];
      REG_MASK_LEFT: next_rdata[ADDR_W-1:0] = mask_reg[PORT_LEFT];
      REG_MASK_RIGHT: next_rdata[ADDR_W-1:0] = mask_reg[PORT_RIGHT];
      REG_MIRROR_LEFT: next_rdata[ADDR_W-1:0] = mirror[PORT_LEFT];
      REG_MIRROR_RIGHT: next_rdata[ADDR_W-1:0] = mirror[PORT_RIGHT];
      // unmapped offsets answer with an error and read as zero
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end else if (apb_access && !PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : next_rdata;
      PSLVERR_OUT <= next_slverr;
    end else begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end
  end

  // the mask hides events from the level output only, never from status
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= IRQ_RESET;
    end else if (apb_write && PADDR_IN == REG_IRQ_MASK) begin
      irq_mask <= PWDATA_IN[IRQ_W-1:0];
    end
  end

  // a disabled port refuses counter and mask operations but keeps its mailbox
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      port_enable <= PORT_ENABLE_RESET;
    end else if (apb_write && PADDR_IN == REG_PORT_ENABLE) begin
      port_enable <= PWDATA_IN[NPORTS-1:0];
    end
  end

  // write one to clear; a new event in the clearing cycle keeps its bit
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= IRQ_RESET;
    end else if (apb_write && PADDR_IN == REG_IRQ_STATUS) begin
      irq_status <= (irq_status & ~PWDATA_IN[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // registered level, one cycle behind status
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_status & irq_mask);
    end
  end

endmodule

// ### dv/dpm_port_ctrl_monitor.sv
`timescale 1ns/1ps
module dpm_port_ctrl_monitor (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic MASTER_RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [1:0] PORT_CLK_IN,
  input wire logic [1:0] MAILBOX_INT_N_OUT,
  input wire logic [1:0] COUNTER_WRAP_IRQ_N_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // port answers lag the port clock by the pin synchroniser, so look three cycles back
  a_mbox_reset_high: assert property (!MASTER_RESET_N_IN |=> MAILBOX_INT_N_OUT == 2'h3)
    else $error("mailbox flag low under master reset");
  a_wrap_reset_high: assert property ($fell(MASTER_RESET_N_IN) |=> (COUNTER_WRAP_IRQ_N_OUT == 2'h3) [*3])
    else $error("wrap flag low under master reset");
  a_mbox_set_cause: assert property ($fell(MAILBOX_INT_N_OUT[1]) |-> $past(PORT_CLK_IN[0], 3))
    else $error("right mailbox flag fell without a left port edge");
  a_mbox_clear_cause: assert property (MASTER_RESET_N_IN && $rose(MAILBOX_INT_N_OUT[1]) |-> $past(PORT_CLK_IN[1], 3))
    else $error("right mailbox flag rose without a right port edge");
  a_wrap_set_cause: assert property ($fell(COUNTER_WRAP_IRQ_N_OUT[0]) |-> $past(PORT_CLK_IN[0], 3))
    else $error("left wrap flag fell without a left port edge");
  a_ready_one_wait: assert property (PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT)
    else $error("ready not given after one wait state");
  a_ready_one_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_rdata_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data not zero outside ready");
  a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
endmodule
bind dpm_port_ctrl dpm_port_ctrl_monitor i_dpm_port_ctrl_monitor (.REF_CLK_IN, .RSTN_IN, .MASTER_RESET_N_IN,
  .PSEL_IN, .PENABLE_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .PORT_CLK_IN, .MAILBOX_INT_N_OUT,
  .COUNTER_WRAP_IRQ_N_OUT);

// ### dv/port_master_model.sv
`timescale 1ns/1ps
module port_master_model (
  input wire logic clk_in,
  output logic pclk_out,
  output logic rw_out,
  output logic [18:0] addr_out,
  output logic [1:0] be_n_out,
  output logic ce0_n_out,
  output logic ce1_out,
  output logic [4:0] ctl_out
);
  // ctl_out is {wrap select, counter/mask select, clear_n, load strobe_n, enable_n}
  task automatic put(input logic [4:0] c, input logic rw, input logic [18:0] a, input logic on);
    ctl_out <= c;
    rw_out <= rw;
    addr_out <= a;
    be_n_out <= {2{~on}};
    ce0_n_out <= ~on;
    ce1_out <= on;
  endtask
  initial begin
    pclk_out = 1'b0;
    put(5'h0f, 1'b1, 19'h0, 1'b0);
  end
  // pins settle five cycles before the rise and hold five after, beyond the sampling window
  task automatic op(input logic [4:0] c, input logic rw, input logic [18:0] a, input logic on);
    @(posedge clk_in);
    put(c, rw, a, on);
    repeat (5) @(posedge clk_in);
    pclk_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    pclk_out <= 1'b0;
    // released address lines show the inverse so a stale value cannot pass
    put(5'h0f, 1'b1, ~a, 1'b0);
    repeat (5) @(posedge clk_in);
  endtask
endmodule

// ### dv/tb_dpm_port_ctrl.sv
`timescale 1ns/1ps
module tb_dpm_port_ctrl
  import dpm_pkg::*;
;
  localparam logic [4:0] MLOAD = 5'h04;
  localparam logic [4:0] MRB = 5'h05;
  localparam logic [4:0] MCLR = 5'h00;
  localparam logic [4:0] CLOAD = 5'h0c;
  localparam logic [4:0] CRB = 5'h0d;
  localparam logic [4:0] CCLR = 5'h08;
  localparam logic [4:0] INC = 5'h0e;
  localparam logic [4:0] INCW = 5'h1e;
  localparam logic [4:0] HOLD = 5'h0f;
  logic REF_CLK_IN, RSTN_IN, MASTER_RESET_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT, IRQ_OUT;
  logic [7:0] PADDR_IN;
  logic [31:0] PWDATA_IN, PRDATA_OUT, r;
  logic [1:0] ADDR_OE_OUT, MAILBOX_INT_N_OUT, COUNTER_WRAP_IRQ_N_OUT;
  logic [1:0][18:0] ADDR_OUT;
  wire [1:0] PORT_CLK_IN, READ_WRITE_IN, CHIP_ENABLE0_N_IN, CHIP_ENABLE1_IN;
  wire [1:0][1:0] BYTE_ENABLE_N_IN;
  wire [1:0][18:0] maddr;
  wire [1:0][4:0] ctl;
  wire [1:0][18:0] ADDR_IN = {ADDR_OE_OUT[1] ? ADDR_OUT[1] : maddr[1], ADDR_OE_OUT[0] ? ADDR_OUT[0] : maddr[0]};
  wire [1:0] WRAP_MODE_SELECT_IN = {ctl[1][4], ctl[0][4]};
  wire [1:0] COUNTER_MASK_SELECT_IN = {ctl[1][3], ctl[0][3]};
  wire [1:0] COUNTER_CLEAR_N_IN = {ctl[1][2], ctl[0][2]};
  wire [1:0] ADDRESS_LOAD_STROBE_N_IN = {ctl[1][1], ctl[0][1]};
  wire [1:0] COUNTER_ENABLE_N_IN = {ctl[1][0], ctl[0][0]};
  int fails = 0;
  int n_checks = 0;
  int q;
  logic e;
  logic [7:0] o;
  logic [3:0] m;
  logic [18:0] a;
  logic lanes_on = 1'b1;
  dpm_port_ctrl i_dpm_port_ctrl (.REF_CLK_IN, .RSTN_IN, .MASTER_RESET_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
    .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .IRQ_OUT, .PORT_CLK_IN, .ADDR_IN, .ADDR_OUT,
    .ADDR_OE_OUT, .READ_WRITE_IN, .BYTE_ENABLE_N_IN, .CHIP_ENABLE0_N_IN, .CHIP_ENABLE1_IN, .COUNTER_MASK_SELECT_IN,
    .COUNTER_CLEAR_N_IN, .ADDRESS_LOAD_STROBE_N_IN, .COUNTER_ENABLE_N_IN, .WRAP_MODE_SELECT_IN,
    .MAILBOX_INT_N_OUT, .COUNTER_WRAP_IRQ_N_OUT);
  for (genvar g = 0; g < 2; g++) begin : g_m
    port_master_model u_m (.clk_in(REF_CLK_IN), .pclk_out(PORT_CLK_IN[g]), .rw_out(READ_WRITE_IN[g]),
      .addr_out(maddr[g]), .be_n_out(BYTE_ENABLE_N_IN[g]), .ce0_n_out(CHIP_ENABLE0_N_IN[g]),
      .ce1_out(CHIP_ENABLE1_IN[g]), .ctl_out(ctl[g]));
  end
  task automatic stop_test();
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge REF_CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= ad;
    PWDATA_IN <= d;
    @(posedge REF_CLK_IN);
    PENABLE_IN <= 1'b1;
    // no local limit: only the watchdog ends a wait for ready
    do @(posedge REF_CLK_IN); while (PREADY_OUT !== 1'b1);
    r = PRDATA_OUT;
    e = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(r, x);
  endtask
  task automatic op(input int p, input logic [4:0] c, input logic rw, input logic [18:0] ad);
    if (p == 0) g_m[0].u_m.op(c, rw, ad, lanes_on);
    else g_m[1].u_m.op(c, rw, ad, lanes_on);
  endtask
  task automatic pins(input logic [3:0] x);
    chk(32'({COUNTER_WRAP_IRQ_N_OUT, MAILBOX_INT_N_OUT}), 32'(x));
  endtask
  initial begin
    REF_CLK_IN = 1'b0;
    forever #12.5 REF_CLK_IN = ~REF_CLK_IN;
  end
  initial begin
    repeat (20000) @(posedge REF_CLK_IN);
    fails++;
    stop_test();
  end
  initial begin
    {RSTN_IN, MASTER_RESET_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} = '0;
    repeat (16) @(posedge REF_CLK_IN);
    RSTN_IN <= 1'b1;
    MASTER_RESET_N_IN <= 1'b1;
    repeat (4) @(posedge REF_CLK_IN);
    pins(4'hf);
    for (int p = 0; p < 2; p++) begin
      o = 8'(4 * p);
      rd(REG_COUNTER_LEFT + o, 32'h0);
      rd(REG_MASK_LEFT + o, 32'h7ffff);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'hf);
    for (int p = 0; p < 2; p++) begin
      q = 1 - p;
      a = 19'h7fffe + 19'(p);
      m = 4'hf ^ 4'(1 << p);
      op(q, CLOAD, 1'b0, 19'h7fffd);
      pins(4'hf);
      op(p, CLOAD, 1'b0, a);
      pins(4'hf);
      op(q, CLOAD, 1'b0, a);
      pins(m);
      chk(32'(IRQ_OUT), 32'h1);
      op(q, CLOAD, 1'b1, a);
      pins(m);
      op(p, CLOAD, 1'b1, a);
      pins(4'hf);
    end
    rd(REG_IRQ_STATUS, 32'h3);
    apb(1'b1, REG_IRQ_STATUS, 32'h3);
    rd(REG_IRQ_STATUS, 32'h0);
    chk(32'(IRQ_OUT), 32'h0);
    for (int p = 0; p < 2; p++) begin
      o = 8'(4 * p);
      op(p, MLOAD, 1'b1, 19'h3);
      rd(REG_MASK_LEFT + o, 32'h3);
      op(p, MRB, 1'b1, 19'h0);
      chk(32'({ADDR_OE_OUT[p], ADDR_OUT[p]}), 32'h80003);
      // readback holds the lines until the next port edge, so release before a load
      op(p, HOLD, 1'b1, 19'h0);
      op(p, CLOAD, 1'b1, 19'h151);
      rd(REG_MIRROR_LEFT + o, 32'h151);
      op(p, INC, 1'b1, 19'h0);
      chk(32'(COUNTER_WRAP_IRQ_N_OUT[p]), 32'h1);
      op(p, INC, 1'b1, 19'h0);
      rd(REG_COUNTER_LEFT + o, 32'h153);
      chk(32'(COUNTER_WRAP_IRQ_N_OUT[p]), 32'h0);
      op(p, INC, 1'b1, 19'h0);
      rd(REG_COUNTER_LEFT + o, 32'h150);
      for (int k = 0; k < 3; k++) op(p, INC, 1'b1, 19'h0);
      op(p, INCW, 1'b1, 19'h0);
      rd(REG_COUNTER_LEFT + o, 32'h151);
      op(p, CRB, 1'b1, 19'h0);
      chk(32'(ADDR_OUT[p]), 32'h151);
      op(p, HOLD, 1'b1, 19'h0);
      op(p, CCLR, 1'b1, 19'h0);
      rd(REG_COUNTER_LEFT + o, 32'h150);
      op(p, MCLR, 1'b1, 19'h0);
      rd(REG_MASK_LEFT + o, 32'h7ffff);
    end
    rd(REG_IRQ_STATUS, 32'hc);
    // counter ops are refused while the port is disabled
    apb(1'b1, REG_PORT_ENABLE, 32'h0);
    op(0, INC, 1'b1, 19'h0);
    rd(REG_COUNTER_LEFT, 32'h150);
    apb(1'b1, REG_PORT_ENABLE, 32'h3);
    // a mailbox write with chip and byte lanes off must not set the flag
    lanes_on = 1'b0;
    op(0, CLOAD, 1'b0, 19'h7ffff);
    lanes_on = 1'b1;
    pins(4'hf);
    op(1, CLOAD, 1'b0, 19'h7fffe);
    pins(4'he);
    rd(REG_FLAGS, 32'he);
    @(posedge REF_CLK_IN);
    MASTER_RESET_N_IN <= 1'b0;
    #1;
    pins(4'hf);
    repeat (4) @(posedge REF_CLK_IN);
    MASTER_RESET_N_IN <= 1'b1;
    repeat (4) @(posedge REF_CLK_IN);
    rd(REG_COUNTER_LEFT, 32'h0);
    rd(REG_COUNTER_RIGHT, 32'h0);
    rd(REG_IRQ_MASK, 32'hf);
    stop_test();
  end
endmodule
